// ### ccd_pkg.sv
// Shared constants and types of the clock source and domain controller.
package ccd_pkg;

    // ==========================================================
    // Clock rates and derived divider
    // ==========================================================
    localparam int CLK_HZ = 250_000_000;
    localparam int NVM_OSC_HZ = 1_000_000;
    localparam int NVM_DIV = CLK_HZ / NVM_OSC_HZ;
    localparam int DIV_W = 8;

    // ==========================================================
    // Delay counts in oscillator ticks
    // ==========================================================
    localparam int CNT_W = 17;
    localparam int SU_258 = 258;
    localparam int SU_1K = 1024;
    localparam int SU_16K = 16384;
    localparam int SU_32K = 32768;
    localparam int SU_OTHER = 6;
    localparam int RST_DLY_SHORT = 4096;
    localparam int RST_DLY_LONG = 65536;
    localparam int NVM_WRITE_TICKS = 8448;
    localparam int NVM_W = 14;

    // ==========================================================
    // Fuse defaults and source classes
    // ==========================================================
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_DEFAULT = 4'h1;
    localparam logic [1:0] SUT_DEFAULT = 2'h2;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN = 4'hA;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LOWFREQ = 4'h9;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC_MIN = 4'h5;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_INT_MIN = 4'h1;

    // ==========================================================
    // Register map and fields
    // ==========================================================
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_FUSE = 8'h08;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_GO_BIT = 4;
    localparam int CTRL_NVM_BIT = 5;
    localparam logic [2:0] MODE_RESET = 3'h0;

    typedef enum logic [1:0] {
        PH_RST = 2'h0,
        PH_RUN = 2'h1,
        PH_SLEEP = 2'h3,
        PH_WAKE = 2'h2
    } ccd_phase_t;

    typedef enum logic [2:0] {
        SM_IDLE = 3'h0,
        SM_NOISE = 3'h1,
        SM_PDOWN = 3'h2,
        SM_PSAVE = 3'h3,
        SM_STBY = 3'h6,
        SM_XSTBY = 3'h7
    } ccd_sleep_t;

endpackage

// ### ccd_cnt_if.sv
// Interface between the controller and one of its tick counters.
`timescale 1ns/1ps
interface ccd_cnt_if #(parameter int W = 17);
    logic load;
    logic [W-1:0] target;
    logic tick;
    logic done;
    modport ctr (input load, input target, input tick, output done);
    modport user (output load, output target, output tick, input done);
endinterface

// ### ccd_tick_counter.sv
// Down counter of oscillator ticks with a held done flag.
`timescale 1ns/1ps
module ccd_tick_counter #(
    parameter int W = 17
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ccd_cnt_if.ctr cnt
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } ccd_ctr_state_t;

    ccd_ctr_state_t s_r;
    ccd_ctr_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (cnt.load) begin
            s_nxt.cnt = cnt.target;
            s_nxt.done = (cnt.target == '0);
        end else if (!s_r.done && cnt.tick) begin
            s_nxt.cnt = s_r.cnt - W'(1);
            s_nxt.done = (s_r.cnt == W'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '{cnt: '0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cnt.done = s_r.done;
endmodule

// ### ccd_clock_ctrl.sv
// Clock source selection, start-up timing and domain gating controller.
// Operation
// - Four-bit clock select fuse picks crystal, low-frequency, RC, internal RC or external.
// - A fuse bit at one is unprogrammed, at zero programmed.
// - Waking from power-down or power-save counts start-up on the selected source.
// - Reset adds zero, 4,096 or 65,536 watchdog oscillator cycles as configured.
// - Unprogrammed defaults are clock select 0001 and start-up select 10.
// - Core clock feeds register file, status and stack; gating it halts the core.
// - Peripheral clock drives timers and serial ports; async interrupts still wake.
// - Two-wire address match wakes the device while the peripheral clock is gated.
// - Program memory clock is enabled and gated together with the core clock.
// - Async timer domain runs from the 32 kHz crystal, also in sleep except power-down and standby.
// - Converter domain stays active in noise reduction sleep while core and peripheral clocks are gated.
// - The sleep mode gates the clocks of unused modules.
// - A write pending at power-down completes and keeps the oscillator running.
// - Non-volatile writes are timed by a 1 MHz tick regardless of fuses.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module ccd_clock_ctrl #(
    parameter int SU_16K_TICKS = ccd_pkg::SU_16K,
    parameter int SU_32K_TICKS = ccd_pkg::SU_32K,
    parameter int RST_LONG_TICKS = ccd_pkg::RST_DLY_LONG,
    parameter int NVM_TICKS = ccd_pkg::NVM_WRITE_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fuse_loaded_i,
    input wire logic [3:0] clock_source_select_fuses_i,
    input wire logic [1:0] startup_time_fuses_i,
    input wire logic src_osc_tick_i,
    input wire logic watchdog_oscillator_tick_i,
    input wire logic async_xtal_tick_i,
    input wire logic wake_i,
    input wire logic ext_int_async_i,
    input wire logic two_wire_interface_addr_match_i,
    output logic core_clock_en_o,
    output logic peripheral_clock_en_o,
    output logic program_memory_clock_en_o,
    output logic converter_clock_en_o,
    output logic async_timer_clock_en_o,
    output logic domain_rst_o,
    output logic osc_run_o,
    output logic nvm_tick_o,
    output logic nvm_busy_o
);
    localparam int CW = ccd_pkg::CNT_W;

    typedef struct packed {
        ccd_pkg::ccd_phase_t st;
        logic started;
        logic armed;
        logic load_src;
        logic load_wdt;
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic [2:0] mode;
        logic osc_hold;
        logic nvm_busy;
        logic [ccd_pkg::NVM_W-1:0] nvm_cnt;
        logic [ccd_pkg::DIV_W-1:0] div_cnt;
        logic nvm_tick;
        logic [4:0] en;
        logic dom_rst;
        logic osc_run;
        logic ack;
        logic [31:0] dat;
    } ccd_state_t;

    ccd_state_t s_r;
    ccd_state_t s_nxt;
    logic wake_any;
    logic deep_mode;

    ccd_cnt_if #(.W(CW)) src_if ();
    ccd_cnt_if #(.W(CW)) wdt_if ();

    // ==========================================================
    // Start-up and reset delay decode
    // ==========================================================
    function automatic logic [CW-1:0] startup_ticks(input logic [3:0] cs, input logic [1:0] su);
        logic [2:0] k;
        k = {cs[0], su};
        if (cs >= ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) begin
            if (k <= 3'h1) begin
                startup_ticks = CW'(ccd_pkg::SU_258);
            end else if (k <= 3'h4) begin
                startup_ticks = CW'(ccd_pkg::SU_1K);
            end else begin
                startup_ticks = CW'(SU_16K_TICKS);
            end
        end else if (cs == ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_LOWFREQ) begin
            startup_ticks = (su[1] == 1'b0) ? CW'(ccd_pkg::SU_1K) : CW'(SU_32K_TICKS);
        end else begin
            startup_ticks = CW'(ccd_pkg::SU_OTHER);
        end
    endfunction

    function automatic logic [CW-1:0] reset_ticks(input logic [3:0] cs, input logic [1:0] su);
        logic [2:0] k;
        k = {cs[0], su};
        if (cs >= ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) begin
            unique case (k)
                3'h2, 3'h5: reset_ticks = '0;
                3'h0, 3'h3, 3'h6: reset_ticks = CW'(ccd_pkg::RST_DLY_SHORT);
                default: reset_ticks = CW'(RST_LONG_TICKS);
            endcase
        end else begin
            reset_ticks = (su == 2'h0) ? CW'(ccd_pkg::RST_DLY_SHORT) : CW'(RST_LONG_TICKS);
        end
    endfunction

    // ==========================================================
    // Domain gating per phase and sleep mode
    // ==========================================================
    // Bit order is core, peripheral, program memory, converter, async timer.
    function automatic logic [4:0] gate(input ccd_pkg::ccd_phase_t ph, input logic [2:0] md);
        gate = 5'h00;
        unique case (ph)
            ccd_pkg::PH_RST: gate = 5'h00;
            ccd_pkg::PH_RUN: gate = 5'h1F;
            ccd_pkg::PH_WAKE: gate = (md == ccd_pkg::SM_PSAVE) ? 5'h01 : 5'h00;
            ccd_pkg::PH_SLEEP: begin
                unique case (md)
                    ccd_pkg::SM_NOISE: gate = 5'h03;
                    ccd_pkg::SM_PDOWN: gate = 5'h00;
                    ccd_pkg::SM_PSAVE: gate = 5'h01;
                    ccd_pkg::SM_STBY: gate = 5'h00;
                    ccd_pkg::SM_XSTBY: gate = 5'h01;
                    default: gate = 5'h0B;
                endcase
            end
        endcase
    endfunction

    assign wake_any = wake_i | ext_int_async_i | two_wire_interface_addr_match_i;
    assign deep_mode = (s_r.mode == ccd_pkg::SM_PDOWN) || (s_r.mode == ccd_pkg::SM_PSAVE);

    assign src_if.load = s_r.load_src;
    assign src_if.target = startup_ticks(s_r.clock_source_select_fuses, s_r.startup_time_fuses);
    assign src_if.tick = src_osc_tick_i;
    assign wdt_if.load = s_r.load_wdt;
    assign wdt_if.target = reset_ticks(s_r.clock_source_select_fuses, s_r.startup_time_fuses);
    assign wdt_if.tick = watchdog_oscillator_tick_i;

    ccd_tick_counter #(.W(CW)) u_src_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cnt(src_if.ctr)
    );

    ccd_tick_counter #(.W(CW)) u_wdt_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cnt(wdt_if.ctr)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        s_nxt = s_r;
        s_nxt.load_src = 1'b0;
        s_nxt.load_wdt = 1'b0;
        s_nxt.armed = s_r.armed | s_r.load_src;
        s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
        // Fixed 1 MHz tick from the system clock, independent of the fuses.
        if (s_r.div_cnt == ccd_pkg::DIV_W'(ccd_pkg::NVM_DIV - 1)) begin
            s_nxt.div_cnt = '0;
            s_nxt.nvm_tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + ccd_pkg::DIV_W'(1);
            s_nxt.nvm_tick = 1'b0;
        end
        if (s_r.nvm_busy && s_r.nvm_tick) begin
            s_nxt.nvm_cnt = s_r.nvm_cnt - ccd_pkg::NVM_W'(1);
            s_nxt.nvm_busy = (s_r.nvm_cnt != ccd_pkg::NVM_W'(1));
        end
        unique case (s_r.st)
            ccd_pkg::PH_RST: begin
                if (!s_r.started) begin
                    s_nxt.started = 1'b1;
                    s_nxt.load_src = 1'b1;
                    s_nxt.load_wdt = 1'b1;
                    if (fuse_loaded_i) begin
                        s_nxt.clock_source_select_fuses = clock_source_select_fuses_i;
                        s_nxt.startup_time_fuses = startup_time_fuses_i;
                    end
                end else if (s_r.armed && src_if.done && wdt_if.done) begin
                    s_nxt.st = ccd_pkg::PH_RUN;
                    s_nxt.dom_rst = 1'b0;
                end
            end
            ccd_pkg::PH_RUN: begin
            end
            ccd_pkg::PH_SLEEP: begin
                if (deep_mode && s_r.nvm_busy) begin
                    s_nxt.osc_hold = 1'b1;
                end
                if (wake_any) begin
                    if (deep_mode) begin
                        s_nxt.st = ccd_pkg::PH_WAKE;
                        s_nxt.load_src = 1'b1;
                        s_nxt.armed = 1'b0;
                    end else begin
                        s_nxt.st = ccd_pkg::PH_RUN;
                    end
                end
            end
            ccd_pkg::PH_WAKE: begin
                if (s_r.armed && src_if.done) begin
                    s_nxt.st = ccd_pkg::PH_RUN;
                    s_nxt.osc_hold = 1'b0;
                end
            end
        endcase
        // Register writes take effect on the edge that ends the acknowledge.
        if (s_r.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == ccd_pkg::ADR_CTRL) begin
            s_nxt.mode = wb_dat_i[ccd_pkg::CTRL_MODE_LSB +: 3];
            if (wb_dat_i[ccd_pkg::CTRL_GO_BIT] && s_r.st == ccd_pkg::PH_RUN) begin
                s_nxt.st = ccd_pkg::PH_SLEEP;
            end
            if (wb_dat_i[ccd_pkg::CTRL_NVM_BIT] && !s_r.nvm_busy) begin
                s_nxt.nvm_busy = 1'b1;
                s_nxt.nvm_cnt = ccd_pkg::NVM_W'(NVM_TICKS);
            end
        end
        s_nxt.dat = 32'h0000_0000;
        if (s_nxt.ack) begin
            unique case (wb_adr_i)
                ccd_pkg::ADR_CTRL: s_nxt.dat = {29'h0, s_r.mode};
                ccd_pkg::ADR_STATUS: s_nxt.dat = {26'h0, s_r.osc_hold, s_r.nvm_busy,
                                                  s_r.osc_run, s_r.dom_rst, s_r.st};
                ccd_pkg::ADR_FUSE: s_nxt.dat = {18'h0, ~s_r.startup_time_fuses, ~s_r.clock_source_select_fuses, 2'h0,
                                                s_r.startup_time_fuses, s_r.clock_source_select_fuses};
                default: s_nxt.dat = 32'h0000_0000;
            endcase
        end
        // Enables are registered levels of the system clock; the async timer output is then ANDed with the unregistered async_xtal_tick_i.
        s_nxt.en = gate(s_nxt.st, s_nxt.mode);
        s_nxt.osc_run = !(s_nxt.st == ccd_pkg::PH_SLEEP && (s_nxt.mode == ccd_pkg::SM_PDOWN ||
                        s_nxt.mode == ccd_pkg::SM_PSAVE)) || s_nxt.nvm_busy || s_nxt.osc_hold;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '{st: ccd_pkg::PH_RST, started: 1'b0, armed: 1'b0, load_src: 1'b0,
                     load_wdt: 1'b0, clock_source_select_fuses: ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_DEFAULT,
                     startup_time_fuses: ccd_pkg::SUT_DEFAULT, mode: ccd_pkg::MODE_RESET, osc_hold: 1'b0,
                     nvm_busy: 1'b0, nvm_cnt: '0, div_cnt: '0, nvm_tick: 1'b0, en: 5'h00,
                     dom_rst: 1'b1, osc_run: 1'b1, ack: 1'b0, dat: 32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign core_clock_en_o = s_r.en[4];
    assign peripheral_clock_en_o = s_r.en[3];
    assign program_memory_clock_en_o = s_r.en[2];
    assign converter_clock_en_o = s_r.en[1];
    assign async_timer_clock_en_o = s_r.en[0] & async_xtal_tick_i;
    assign domain_rst_o = s_r.dom_rst;
    assign osc_run_o = s_r.osc_run;
    assign nvm_tick_o = s_r.nvm_tick;
    assign nvm_busy_o = s_r.nvm_busy;
    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;

    // ==========================================================
    // Assertions
    // ==========================================================
    a_core_flash_pair: assert property (
        @(posedge clk_i) disable iff (rst_i) core_clock_en_o == program_memory_clock_en_o)
        else $error("program memory clock not paired with core clock");

    a_rst_holds_domains: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_RST) |-> (domain_rst_o && !core_clock_en_o))
        else $error("domain released or clocked during reset phase");

    a_release_needs_wdt: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(domain_rst_o) |-> $past(wdt_if.done) && $past(src_if.done))
        else $error("domain reset released before delay counts finished");

    a_noise_conv_on: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_SLEEP && s_r.mode == ccd_pkg::SM_NOISE) |->
        (converter_clock_en_o && !core_clock_en_o && !peripheral_clock_en_o))
        else $error("converter domain wrong in noise reduction sleep");

    a_deep_wake_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_SLEEP && deep_mode && wake_any) |=>
        (s_r.st == ccd_pkg::PH_WAKE) ##1 s_r.armed [*1] ##0 !core_clock_en_o)
        else $error("deep sleep wake did not start the oscillator count");

    a_async_wake: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_SLEEP && !deep_mode && ext_int_async_i) |=>
        (s_r.st == ccd_pkg::PH_RUN) ##1 core_clock_en_o)
        else $error("async interrupt did not wake the device");

    a_osc_kept: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_SLEEP && s_r.mode == ccd_pkg::SM_PDOWN && s_r.nvm_busy) |=>
        osc_run_o)
        else $error("oscillator stopped while a write is pending");

    a_tick_spacing: assert property (
        @(posedge clk_i) disable iff (rst_i)
        nvm_tick_o |=> !nvm_tick_o [*8] ##242 nvm_tick_o)
        else $error("write timing tick is not one per microsecond");

    a_default_fuses: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!s_r.started && !fuse_loaded_i) |=>
        (s_r.clock_source_select_fuses == ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_DEFAULT && s_r.startup_time_fuses == ccd_pkg::SUT_DEFAULT))
        else $error("blank fuses did not give the factory defaults");

    a_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for more than one cycle");

    a_pdown_all_off: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_SLEEP && s_r.mode == ccd_pkg::SM_PDOWN) |->
        (s_r.en == 5'h00))
        else $error("a clock domain runs in power-down sleep");

    a_wake_core_off: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ccd_pkg::PH_WAKE) |-> (!core_clock_en_o && !program_memory_clock_en_o))
        else $error("core clocked before the start-up count ended");
endmodule

// ### ccd_osc_model.sv
// Tick model of the oscillator sources that feed the clock controller.
`timescale 1ns/1ps
module ccd_osc_model #(
    parameter int SRC_DIV = 3,
    parameter int WDT_DIV = 5,
    parameter int XTAL_DIV = 7
) (
    input wire logic clk_i,
    output logic src_osc_tick_o = 1'b0,
    output logic watchdog_oscillator_tick_o = 1'b0,
    output logic async_xtal_tick_o = 1'b0
);
    // ==========================================================
    // Tick generation
    // ==========================================================
    int cnt_r = 0;
    always_ff @(posedge clk_i) begin
        cnt_r <= cnt_r + 1;
        src_osc_tick_o <= (cnt_r % SRC_DIV) == 0;
        watchdog_oscillator_tick_o <= (cnt_r % WDT_DIV) == 0;
        async_xtal_tick_o <= (cnt_r % XTAL_DIV) == 0;
    end
endmodule

// ### clock_source_and_domain_control_tb.sv
// Self-checking testbench of the clock source and domain controller.
`timescale 1ns/1ps
module clock_source_and_domain_control_tb;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    localparam int RST_TICKS = 40;
    localparam int WDT_DIV = 5;
    typedef struct packed {logic [2:0] mode; logic [4:0] en; logic osc;} ccd_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fl = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, cks = 4'h0;
    logic [1:0] startup_time_fuses = 2'h0;
    logic [2:0] wake_vec = 3'h0;
    logic [31:0] wd = 32'h0, rd, dat_o;
    logic ack, core, peri, prog, conv, asy, drst, osc, ntick, nbusy, st, wt, xt;
    int checks = 0, n_fail = 0, na, n;
    ccd_row_t rows [7] = '{'{3'h0, 5'h0B, 1'b1}, '{3'h1, 5'h03, 1'b1}, '{3'h2, 5'h00, 1'b0},
        '{3'h3, 5'h01, 1'b0}, '{3'h6, 5'h00, 1'b1}, '{3'h7, 5'h01, 1'b1}, '{3'h4, 5'h0B, 1'b1}};
    ccd_osc_model #(.WDT_DIV(WDT_DIV)) osc_u (.clk_i(clk_i), .src_osc_tick_o(st),
        .watchdog_oscillator_tick_o(wt), .async_xtal_tick_o(xt));
    ccd_clock_ctrl #(.SU_16K_TICKS(20), .SU_32K_TICKS(24), .RST_LONG_TICKS(RST_TICKS),
        .NVM_TICKS(30)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .fuse_loaded_i(fl), .clock_source_select_fuses_i(cks),
        .startup_time_fuses_i(startup_time_fuses), .src_osc_tick_i(st), .watchdog_oscillator_tick_i(wt),
        .async_xtal_tick_i(xt), .wake_i(wake_vec[0]), .ext_int_async_i(wake_vec[1]),
        .two_wire_interface_addr_match_i(wake_vec[2]), .core_clock_en_o(core),
        .peripheral_clock_en_o(peri), .program_memory_clock_en_o(prog),
        .converter_clock_en_o(conv), .async_timer_clock_en_o(asy), .domain_rst_o(drst),
        .osc_run_o(osc), .nvm_tick_o(ntick), .nvm_busy_o(nbusy));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wd <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        chk("wb_ack", 1, ack);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic wait_up();
        n = 0;
        @(negedge clk_i);
        chk("held_rst", 5'h10, {drst, core, peri, prog, conv});
        while (drst !== 1'b0 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        chk("rst_long", 1, n >= (RST_TICKS - 1) * WDT_DIV);
        chk("rst_short", 1, n <= (RST_TICKS + 1) * WDT_DIV);
        chk("all_on", 4'hF, {core, peri, prog, conv});
    endtask
    task automatic count_async();
        na = 0;
        repeat (30) begin
            @(negedge clk_i);
            if (asy === 1'b1) na++;
        end
    endtask
    task automatic wake_up(input int i);
        @(posedge clk_i);
        wake_vec <= 3'h1 << (i % 3);
        n = 0;
        while (core !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        chk("woken", 4'hF, {core, peri, prog, conv});
        @(posedge clk_i);
        wake_vec <= 3'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] fw(input logic [3:0] c, input logic [1:0] s);
        return {18'h0, ~s, ~c, 2'h0, s, c};
    endfunction
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_up();
        wb(1'b0, ccd_pkg::ADR_FUSE, 32'h0);
        chk("fuse_dflt", fw(ccd_pkg::CLOCK_SOURCE_SELECT_FUSES_DEFAULT, ccd_pkg::SUT_DEFAULT), rd);
        wb(1'b0, ccd_pkg::ADR_STATUS, 32'h0);
        chk("status", 4'h9, rd[3:0]);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 0, rd);
        $display("test reset done");
        chk("write_idle", 0, nbusy);
        foreach (rows[i]) begin
            wb(1'b1, ccd_pkg::ADR_CTRL, (32'h1 << ccd_pkg::CTRL_GO_BIT) | rows[i].mode);
            repeat (3) @(negedge clk_i);
            count_async();
            chk("sleep_en", rows[i].en[4:1], {core, peri, prog, conv});
            chk("async_en", rows[i].en[0], na > 0);
            chk("osc_run", rows[i].osc, osc);
            wake_up(i);
            $display("test sleep mode %0d done", rows[i].mode);
        end
        wb(1'b1, ccd_pkg::ADR_CTRL, 32'h1 << ccd_pkg::CTRL_NVM_BIT);
        @(negedge clk_i);
        chk("nvm_busy", 1, nbusy);
        n = 0;
        while (ntick !== 1'b1 && n < 600) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (ntick !== 1'b1 && n < 600);
        chk("nvm_period", ccd_pkg::NVM_DIV, n);
        wb(1'b1, ccd_pkg::ADR_CTRL, (32'h1 << ccd_pkg::CTRL_GO_BIT) | ccd_pkg::SM_PDOWN);
        na = 0;
        n = 0;
        while (nbusy !== 1'b0 && n < 10000) begin
            @(negedge clk_i);
            if (osc !== 1'b1) na++;
            n++;
        end
        repeat (5) @(negedge clk_i);
        chk("osc_kept", 1, {na[4:0], osc});
        wake_up(0);
        $display("test write in power-down done");
        @(posedge clk_i);
        rst_i <= 1'b1; fl <= 1'b1; cks <= 4'hF; startup_time_fuses <= 2'h3;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_up();
        wb(1'b0, ccd_pkg::ADR_FUSE, 32'h0);
        chk("fuse_read", fw(4'hF, 2'h3), rd);
        $display("test fused reset done");
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule
